// File: verilog/aaom_core.sv
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "aaom_defs.svh"

module aaom_core
(
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire aaom_pkg::aaom_read_t readings,
   input  wire logic                power_up_enable,
   output logic signed [15:0]       dac_code,
   output logic                     output_active
);
   import aaom_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   aaom_ctrl_t        ctrl_reg;
   logic [6:0]        warm_pct_reg;
   aaom_val_t         setpoint_reg;
   aaom_val_t         mon_neg_reg;
   aaom_val_t         mon_zero_reg;
   aaom_val_t         mon_pos_reg;
   logic signed [15:0] manual_reg;
   logic [31:0]       prdata_reg;
   logic              pready_reg;
   logic              pslverr_reg;
   logic              warm_on_reg;
   logic              pue_meta_reg;
   logic              pue_sync_reg;
   logic [1:0]        init_cnt_reg;
   logic              init_done_reg;
   aaom_state_t       state_reg;
   logic [47:0]       num_reg;
   logic [32:0]       rem_reg;
   logic [31:0]       den_reg;
   logic [5:0]        step_reg;
   logic signed [15:0] mon_code_reg;
   logic signed [15:0] dac_code_reg;
   logic              active_reg;

   logic              setup_phase;
   logic              wr_commit;
   logic              wr_ok;
   logic              addr_ok;
   logic [31:0]       rd_value;
   aaom_ctrl_t        ctrl_wr;
   logic              range_set;
   logic              all_off;
   logic              auto_off_hit;
   aaom_val_t         fb_k;
   aaom_val_t         mon_rd;
   logic signed [32:0] lo_s;
   logic signed [32:0] hi_s;
   logic signed [32:0] den_s;
   logic signed [32:0] diff_s;
   logic [31:0]       diff_c;
   logic [16:0]       span;
   logic signed [15:0] bottom_code;
   logic [48:0]       prod;
   logic [32:0]       rem_sh;
   logic signed [16:0] q_sum;
   logic [15:0]       warm_code;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic aaom_val_t pick_reading(input aaom_read_t rd, input aaom_unit_t u,
                                              input aaom_input_t sel);
      aaom_val_t v;
      v = '0;
      case (sel)
         AAOM_IN_A : v = (u == AAOM_UNIT_SENSOR) ? rd.sensor[0] : rd.kelvin[0];
         AAOM_IN_B : v = (u == AAOM_UNIT_SENSOR) ? rd.sensor[1] : rd.kelvin[1];
         AAOM_IN_C : v = (u == AAOM_UNIT_SENSOR) ? rd.sensor[2] : rd.kelvin[2];
         AAOM_IN_D : v = (u == AAOM_UNIT_SENSOR) ? rd.sensor[3] : rd.kelvin[3];
         default   : v = '0;
      endcase
      if (u == AAOM_UNIT_C)
      begin
         v = v - `AAOM_CELSIUS_OFS;
      end
      return v;
   endfunction : pick_reading

   function automatic logic value_legal(input aaom_val_t v, input aaom_unit_t u);
      logic ok;
      ok = 1'b0;
      case (u)
         AAOM_UNIT_K      : ok = (v >= `AAOM_K_MIN) && (v <= `AAOM_K_MAX);
         AAOM_UNIT_C      : ok = (v >= `AAOM_C_MIN) && (v <= `AAOM_C_MAX);
         AAOM_UNIT_SENSOR : ok = (v >= `AAOM_S_MIN) && (v <= `AAOM_S_MAX);
         default          : ok = 1'b0;
      endcase
      return ok;
   endfunction : value_legal

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   assign setup_phase = psel && !penable;
   assign wr_commit   = psel && penable && pready_reg && pwrite && !pslverr_reg;
   assign ctrl_wr     = aaom_ctrl_t'(pwdata[9:0]);

   always_comb
   begin
      addr_ok = 1'b1;
      wr_ok   = 1'b1;
      case (paddr)
         `AAOM_WARM_PCT_OFS : wr_ok = (pwdata[31:7] == 25'h0) && (pwdata[6:0] <= `AAOM_WARM_PCT_MAX);
         `AAOM_SETPOINT_OFS : wr_ok = value_legal(aaom_val_t'(pwdata), AAOM_UNIT_K);
         `AAOM_MON_NEG_OFS,
         `AAOM_MON_ZERO_OFS,
         `AAOM_MON_POS_OFS  : wr_ok = value_legal(aaom_val_t'(pwdata), ctrl_reg.unit);
         `AAOM_CTRL_OFS     : wr_ok = (ctrl_wr.unit != 2'b11) && (ctrl_wr.input_sel <= AAOM_IN_D);
         `AAOM_MANUAL_OFS,
         `AAOM_CMD_OFS      : wr_ok = 1'b1;
         `AAOM_STATUS_OFS   : wr_ok = 1'b0;
         default            : addr_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      case (paddr)
         `AAOM_CTRL_OFS     : rd_value = {22'h0, ctrl_reg};
         `AAOM_WARM_PCT_OFS : rd_value = {25'h0, warm_pct_reg};
         `AAOM_SETPOINT_OFS : rd_value = setpoint_reg;
         `AAOM_MON_NEG_OFS  : rd_value = mon_neg_reg;
         `AAOM_MON_ZERO_OFS : rd_value = mon_zero_reg;
         `AAOM_MON_POS_OFS  : rd_value = mon_pos_reg;
         `AAOM_MANUAL_OFS   : rd_value = {16'h0, manual_reg};
         `AAOM_STATUS_OFS   : rd_value = {13'h0, (state_reg != AAOM_ST_IDLE), warm_on_reg,
                                          active_reg, dac_code_reg};
         default            : rd_value = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0;
      end
      else if (setup_phase)
      begin
         pready_reg  <= 1'b1;
         pslverr_reg <= !addr_ok || (pwrite && !wr_ok);
         prdata_reg  <= pwrite ? 32'h0 : rd_value;
      end
      else
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   assign pready  = pready_reg;
   assign pslverr = pready_reg && pslverr_reg;
   assign prdata  = prdata_reg;

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         warm_pct_reg <= `AAOM_WARM_PCT_RST;
         setpoint_reg <= `AAOM_SETPOINT_RST;
         mon_neg_reg  <= `AAOM_MON_NEG_RST;
         mon_zero_reg <= `AAOM_MON_ZERO_RST;
         mon_pos_reg  <= `AAOM_MON_POS_RST;
         manual_reg   <= 16'sh0000;
      end
      else if (wr_commit)
      begin
         case (paddr)
            `AAOM_WARM_PCT_OFS : warm_pct_reg <= pwdata[6:0];
            `AAOM_SETPOINT_OFS : setpoint_reg <= aaom_val_t'(pwdata);
            `AAOM_MON_NEG_OFS  : mon_neg_reg  <= aaom_val_t'(pwdata);
            `AAOM_MON_ZERO_OFS : mon_zero_reg <= aaom_val_t'(pwdata);
            `AAOM_MON_POS_OFS  : mon_pos_reg  <= aaom_val_t'(pwdata);
            `AAOM_MANUAL_OFS   : manual_reg   <= pwdata[15:0];
            default            : manual_reg   <= manual_reg;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Power-up enable capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pue_meta_reg  <= 1'b0;
         pue_sync_reg  <= 1'b0;
         init_cnt_reg  <= 2'h0;
         init_done_reg <= 1'b0;
      end
      else
      begin
         pue_meta_reg <= power_up_enable;
         pue_sync_reg <= pue_meta_reg;
         if (init_cnt_reg != `AAOM_INIT_WAIT)
         begin
            init_cnt_reg <= init_cnt_reg + 2'h1;
         end
         init_done_reg <= (init_cnt_reg == `AAOM_INIT_WAIT);
      end
   end

   // ----------------------------------------------------------------
   // Control register and range setting
   // ----------------------------------------------------------------
   assign all_off   = wr_commit && (paddr == `AAOM_CMD_OFS) && pwdata[`AAOM_CMD_ALLOFF_BIT];
   assign range_set = wr_commit && (paddr == `AAOM_CTRL_OFS) && ctrl_wr.range_on
                      && (ctrl_wr.output_mode_command != AAOM_MODE_MONITOR);
   assign fb_k      = pick_reading(readings, AAOM_UNIT_K, ctrl_reg.input_sel);
   assign auto_off_hit = (ctrl_reg.output_mode_command == AAOM_MODE_WARMUP) && !ctrl_reg.continuous
                         && ctrl_reg.range_on && (ctrl_reg.input_sel != AAOM_IN_NONE)
                         && (fb_k >= setpoint_reg);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_reg.output_mode_command <= AAOM_MODE_OFF;
         ctrl_reg.continuous          <= 1'b1;
         ctrl_reg.bipolar             <= 1'b0;
         ctrl_reg.range_on            <= 1'b0;
         ctrl_reg.input_sel           <= AAOM_IN_NONE;
         ctrl_reg.unit                <= AAOM_UNIT_K;
      end
      else
      begin
         if (wr_commit && (paddr == `AAOM_CTRL_OFS))
         begin
            ctrl_reg.output_mode_command <= ctrl_wr.output_mode_command;
            ctrl_reg.continuous          <= ctrl_wr.continuous;
            ctrl_reg.bipolar             <= ctrl_wr.bipolar;
            ctrl_reg.input_sel           <= ctrl_wr.input_sel;
            ctrl_reg.unit                <= ctrl_wr.unit;
         end
         if (range_set)
         begin
            ctrl_reg.range_on <= 1'b1;
         end
         else if (wr_commit && (paddr == `AAOM_CTRL_OFS))
         begin
            ctrl_reg.range_on <= 1'b0;
         end
         else if (all_off)
         begin
            ctrl_reg.range_on <= 1'b0;
         end
         else if (auto_off_hit)
         begin
            ctrl_reg.range_on <= 1'b0;
         end
         else if (!init_done_reg && (init_cnt_reg == `AAOM_INIT_WAIT) && pue_sync_reg)
         begin
            ctrl_reg.range_on <= 1'b1;
         end
         if (ctrl_reg.output_mode_command == AAOM_MODE_MONITOR)
         begin
            ctrl_reg.range_on <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Warm-up switching
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         warm_on_reg <= 1'b0;
      end
      else if (range_set && !ctrl_reg.range_on)
      begin
         warm_on_reg <= 1'b1;
      end
      else if (!ctrl_reg.range_on || (ctrl_reg.input_sel == AAOM_IN_NONE))
      begin
         warm_on_reg <= 1'b0;
      end
      else if (ctrl_reg.range_on && !init_done_reg)
      begin
         warm_on_reg <= 1'b1;
      end
      else if (warm_on_reg && (fb_k >= setpoint_reg))
      begin
         warm_on_reg <= 1'b0;
      end
      else if (!warm_on_reg && ctrl_reg.continuous && (fb_k <= setpoint_reg - `AAOM_HYST_MK))
      begin
         warm_on_reg <= 1'b1;
      end
   end

   assign warm_code = 16'((32'(warm_pct_reg) * 32'(`AAOM_CODE_POS_FS)) / 32'd100);

   // ----------------------------------------------------------------
   // Monitor scaling
   // ----------------------------------------------------------------
   assign mon_rd      = pick_reading(readings, ctrl_reg.unit, ctrl_reg.input_sel);
   assign lo_s        = ctrl_reg.bipolar ? 33'(mon_neg_reg) : 33'(mon_zero_reg);
   assign hi_s        = 33'(mon_pos_reg);
   assign den_s       = hi_s - lo_s;
   assign diff_s      = 33'(mon_rd) - lo_s;
   assign span        = ctrl_reg.bipolar ? `AAOM_SPAN_BI : `AAOM_SPAN_UNI;
   assign bottom_code = ctrl_reg.bipolar ? `AAOM_CODE_NEG_FS : 16'sh0000;
   assign diff_c      = (diff_s < 0) ? 32'h0 : ((diff_s > den_s) ? den_s[31:0] : diff_s[31:0]);
   assign prod        = 49'(diff_c) * 49'(span);
   assign rem_sh      = {rem_reg[31:0], num_reg[47]};
   assign q_sum       = 17'(bottom_code) + 17'(num_reg[15:0]);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg    <= AAOM_ST_IDLE;
         num_reg      <= 48'h0;
         rem_reg      <= 33'h0;
         den_reg      <= 32'h0;
         step_reg     <= 6'h0;
         mon_code_reg <= 16'sh0000;
      end
      else
      begin
         case (state_reg)
            AAOM_ST_IDLE :
            begin
               if (ctrl_reg.output_mode_command == AAOM_MODE_MONITOR)
               begin
                  if (ctrl_reg.input_sel == AAOM_IN_NONE)
                  begin
                     mon_code_reg <= 16'sh0000;
                  end
                  else if (den_s <= 0)
                  begin
                     mon_code_reg <= (33'(mon_rd) >= hi_s) ? `AAOM_CODE_POS_FS : bottom_code;
                  end
                  else
                  begin
                     num_reg   <= prod[47:0];
                     rem_reg   <= 33'h0;
                     den_reg   <= den_s[31:0];
                     step_reg  <= 6'h0;
                     state_reg <= AAOM_ST_DIV;
                  end
               end
            end
            AAOM_ST_DIV :
            begin
               if (rem_sh >= {1'b0, den_reg})
               begin
                  rem_reg <= rem_sh - {1'b0, den_reg};
                  num_reg <= {num_reg[46:0], 1'b1};
               end
               else
               begin
                  rem_reg <= rem_sh;
                  num_reg <= {num_reg[46:0], 1'b0};
               end
               step_reg <= step_reg + 6'h1;
               if (step_reg == `AAOM_DIV_STEPS - 6'h1)
               begin
                  state_reg <= AAOM_ST_DONE;
               end
            end
            AAOM_ST_DONE :
            begin
               mon_code_reg <= q_sum[15:0];
               state_reg    <= AAOM_ST_IDLE;
            end
            default :
            begin
               state_reg <= AAOM_ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Output selection
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dac_code_reg <= 16'sh0000;
         active_reg   <= 1'b0;
      end
      else
      begin
         case (ctrl_reg.output_mode_command)
            AAOM_MODE_MONITOR :
            begin
               dac_code_reg <= mon_code_reg;
               active_reg   <= 1'b1;
            end
            AAOM_MODE_WARMUP :
            begin
               dac_code_reg <= (ctrl_reg.range_on && warm_on_reg) ? warm_code : 16'sh0000;
               active_reg   <= ctrl_reg.range_on && warm_on_reg;
            end
            AAOM_MODE_OPEN :
            begin
               if (!ctrl_reg.range_on)
               begin
                  dac_code_reg <= 16'sh0000;
               end
               else if (!ctrl_reg.bipolar && manual_reg[15])
               begin
                  dac_code_reg <= 16'sh0000;
               end
               else if (manual_reg == 16'sh8000)
               begin
                  dac_code_reg <= `AAOM_CODE_NEG_FS;
               end
               else
               begin
                  dac_code_reg <= manual_reg;
               end
               active_reg <= ctrl_reg.range_on;
            end
            default :
            begin
               dac_code_reg <= 16'sh0000;
               active_reg   <= 1'b0;
            end
         endcase
      end
   end

   assign dac_code      = dac_code_reg;
   assign output_active = active_reg;

endmodule : aaom_core

// File: verilog/aaom_defs.svh
// Summary of operation
// - Warm-up drive equals full scale times fraction.
// - Warm-up drives only while range is on.
// - Control input selects warm-up feedback reading.
// - Auto-off: setpoint reached zeroes output, range off.
// - Auto-off restarts whenever range switched on again.
// - Continuous: off at setpoint, on 1 K below.
// - Continuous mode never clears range by itself.
// - Power-up enable restores range on after reset.
// - Monitor output tracks scaled selected reading continuously.
// - Monitor mode always enabled, ignores all-off command.
// - Monitor input none or A to D, default none.
// - Monitor units kelvin, Celsius, sensor; default kelvin.
// - Polarity selects unipolar or bipolar span.
// - Bipolar: negative endpoint gives negative full scale.
// - Unipolar: zero endpoint gives zero output.
// - Positive endpoint gives positive full scale.
// - Defaults unipolar, endpoints 0 K, 0 K, 1000 K.
// - Endpoint writes outside selected unit range rejected.
`ifndef AAOM_DEFS_SVH
`define AAOM_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AAOM_CTRL_OFS        8'h00
`define AAOM_WARM_PCT_OFS    8'h04
`define AAOM_SETPOINT_OFS    8'h08
`define AAOM_MON_NEG_OFS     8'h0c
`define AAOM_MON_ZERO_OFS    8'h10
`define AAOM_MON_POS_OFS     8'h14
`define AAOM_MANUAL_OFS      8'h18
`define AAOM_STATUS_OFS      8'h1c
`define AAOM_CMD_OFS         8'h20

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define AAOM_CTRL_MODE_LSB   0
`define AAOM_CTRL_CONT_BIT   2
`define AAOM_CTRL_BIPOL_BIT  3
`define AAOM_CTRL_RANGE_BIT  4
`define AAOM_CTRL_INPUT_LSB  5
`define AAOM_CTRL_UNIT_LSB   8
`define AAOM_CMD_ALLOFF_BIT  0

// ----------------------------------------------------------------
// Reset values and limits (readings in thousandths of a unit)
// ----------------------------------------------------------------
`define AAOM_WARM_PCT_RST    7'h64
`define AAOM_WARM_PCT_MAX    7'h64
`define AAOM_SETPOINT_RST    32'sh0004_93e0
`define AAOM_MON_NEG_RST     32'sh0000_0000
`define AAOM_MON_ZERO_RST    32'sh0000_0000
`define AAOM_MON_POS_RST     32'sh000f_4240
`define AAOM_HYST_MK         32'sh0000_03e8
`define AAOM_CELSIUS_OFS     32'sh0004_2afe
`define AAOM_K_MIN           32'sh0000_0000
`define AAOM_K_MAX           32'sh0098_9676
`define AAOM_C_MIN           32'shfffb_d502
`define AAOM_C_MAX           32'sh0094_6b78
`define AAOM_S_MIN           32'shfffe_7960
`define AAOM_S_MAX           32'sh0098_9680

// ----------------------------------------------------------------
// Output codes and timing
// ----------------------------------------------------------------
`define AAOM_CODE_POS_FS     16'sh7fff
`define AAOM_CODE_NEG_FS     16'sh8001
`define AAOM_SPAN_UNI        17'h0_7fff
`define AAOM_SPAN_BI         17'h0_fffe
`define AAOM_DIV_STEPS       6'h30
`define AAOM_INIT_WAIT       2'h2

`endif

// File: verilog/aaom_pkg.sv
package aaom_pkg;

   typedef logic signed [31:0] aaom_val_t;

   typedef enum logic [1:0]
   {
      AAOM_MODE_OFF     = 2'b00,
      AAOM_MODE_MONITOR = 2'b01,
      AAOM_MODE_OPEN    = 2'b10,
      AAOM_MODE_WARMUP  = 2'b11
   } aaom_mode_t;

   typedef enum logic [1:0]
   {
      AAOM_UNIT_K      = 2'b00,
      AAOM_UNIT_C      = 2'b01,
      AAOM_UNIT_SENSOR = 2'b10
   } aaom_unit_t;

   typedef enum logic [2:0]
   {
      AAOM_IN_NONE = 3'b000,
      AAOM_IN_A    = 3'b001,
      AAOM_IN_B    = 3'b010,
      AAOM_IN_C    = 3'b011,
      AAOM_IN_D    = 3'b100
   } aaom_input_t;

   typedef enum logic [1:0]
   {
      AAOM_ST_IDLE = 2'b00,
      AAOM_ST_DIV  = 2'b01,
      AAOM_ST_DONE = 2'b10
   } aaom_state_t;

   typedef struct packed
   {
      aaom_val_t [3:0] kelvin;
      aaom_val_t [3:0] sensor;
   } aaom_read_t;

   typedef struct packed
   {
      aaom_unit_t  unit;
      aaom_input_t input_sel;
      logic        range_on;
      logic        bipolar;
      logic        continuous;
      aaom_mode_t  output_mode_command;
   } aaom_ctrl_t;

endpackage : aaom_pkg

// File: tb/aaom_core_monitor.sv
`timescale 1ns/1ps
module aaom_core_monitor
   import aaom_pkg::*;
(
   input wire logic               clk,
   input wire logic               arst_n,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [7:0]         paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic signed [15:0] dac_code,
   input wire logic               output_active
);
   // ---------------------------------------
   // Shadow of committed settings.
   // ---------------------------------------
   aaom_ctrl_t         ctrl_reg;
   logic [6:0]         pct_reg;
   logic [7:0]         quiet_reg;
   logic               wr, acc, mon, warm, quiet;
   logic signed [15:0] warm_exp;
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite && !pslverr;
   assign mon = ctrl_reg.output_mode_command == AAOM_MODE_MONITOR;
   assign warm = ctrl_reg.output_mode_command == AAOM_MODE_WARMUP;
   assign quiet = quiet_reg >= 8'h40;
   assign warm_exp = 16'((32'(pct_reg) * 32767) / 100);
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_reg <= aaom_ctrl_t'(10'h004);
         pct_reg <= 7'h64;
         quiet_reg <= 8'h00;
      end
      else
      begin
         if (wr && paddr == 8'h00)
            ctrl_reg <= aaom_ctrl_t'(pwdata[9:0]);
         if (wr && paddr == 8'h04)
            pct_reg <= pwdata[6:0];
         if (wr)
            quiet_reg <= 8'h00;
         else if (!quiet)
            quiet_reg <= quiet_reg + 8'h01;
      end
   end
   // ---------------------------------------
   // Properties.
   // ---------------------------------------
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   AST_MON_ACTIVE: assert property (mon && quiet |-> output_active)
      else $error("monitor inactive");
   AST_WARM_LEVEL: assert property (warm && quiet && output_active && ctrl_reg.input_sel != AAOM_IN_NONE |-> dac_code == warm_exp)
      else $error("warm level wrong");
   AST_WARM_ZERO: assert property (warm && quiet && !output_active |-> dac_code == 16'sh0000)
      else $error("warm off not zero");
   AST_UNI_NONNEG: assert property (mon && quiet && !ctrl_reg.bipolar |-> !dac_code[15])
      else $error("unipolar negative");
   AST_NO_MIN_CODE: assert property (dac_code != 16'sh8000)
      else $error("code below span");
   AST_AUTO_OFF_HOLD: assert property (warm && !ctrl_reg.continuous && !$past(wr) && $fell(output_active)
                                       |=> !output_active)
      else $error("auto-off resumed");
   AST_CTRL_FIELDS: assert property (acc && !pwrite && paddr == 8'h00 |-> prdata[7:5] <= 3'h4 && prdata[9:8] != 2'h3)
      else $error("ctrl field illegal");
   AST_SEL_REFUSED: assert property (acc && pwrite && paddr == 8'h00 && pwdata[7:5] > 3'h4 |-> pslverr)
      else $error("bad input taken");
   AST_K_RANGE: assert property (acc && pwrite && paddr inside {8'h0c, 8'h10, 8'h14} && ctrl_reg.unit == AAOM_UNIT_K
                                 && pwdata[31] |-> pslverr)
      else $error("negative kelvin taken");
endmodule : aaom_core_monitor

bind aaom_core aaom_core_monitor u_aaom_core_monitor (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .dac_code, .output_active);

// File: tb/aaom_daq_model.sv
`timescale 1ns/1ps
module aaom_daq_model
(
   input  wire logic signed [15:0] dac_code,
   input  wire logic               clk,
   output logic signed [31:0]      level_mv
);
   // Converts the output code to the level seen by the acquisition input.
   always_ff @(posedge clk)
   begin
      level_mv <= (32'(dac_code) * 10000) / 32767;
   end
endmodule : aaom_daq_model

// File: tb/aaom_core_tb.sv
`timescale 1ns/1ps
module aaom_core_tb;
   import aaom_pkg::*;
   logic               clk, arst_n, psel, penable, pwrite, pready, pslverr, s;
   logic               power_up_enable, output_active;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, r;
   aaom_read_t         readings;
   logic signed [15:0] dac_code;
   logic signed [31:0] level_mv;
   int                 n_errors, n_tests;
   aaom_core u_aaom_core (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .readings, .power_up_enable, .dac_code, .output_active);
   aaom_daq_model u_aaom_daq_model (.clk, .dac_code, .level_mv);
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ---------------------------------------
   // Tasks.
   // ---------------------------------------
   task results;
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (pready !== 1'b1 && i < 16);
      if (i >= 16)
      begin
         n_errors++;
         results;
      end
      r = prdata;
      s = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk("pslverr", {31'h0, s}, {31'h0, e});
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("prdata", r, e);
   endtask : rd
   task code(input int n, input logic [15:0] e);
      repeat (n) @(posedge clk);
      chk("dac_code", {16'h0, dac_code}, {16'h0, e});
   endtask : code
   // ---------------------------------------
   // Sequence.
   // ---------------------------------------
   initial
   begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      readings = '0;
      power_up_enable = 1'b0;
      n_errors = 0;
      n_tests = 0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd(8'h00, 32'h004);
      rd(8'h04, 32'h064);
      rd(8'h10, 32'h0);
      rd(8'h14, 32'h000f4240);
      wr(8'h40, 32'h0, 1'b1);
      wr(8'h00, 32'h0a1, 1'b1);
      wr(8'h0c, 32'hffffffff, 1'b1);
      wr(8'h00, 32'h021, 1'b0);
      readings.kelvin[0] <= 32'sd1000000;
      code(110, 16'h7fff);
      chk("level_mv", level_mv, 32'd10000);
      readings.kelvin[0] <= 32'sd0;
      code(110, 16'h0000);
      readings.kelvin[0] <= 32'sd2000000;
      code(110, 16'h7fff);
      wr(8'h00, 32'h029, 1'b0);
      readings.kelvin[0] <= 32'sd0;
      code(110, 16'h8001);
      readings.kelvin[0] <= 32'sd500000;
      code(110, 16'h0000);
      wr(8'h20, 32'h1, 1'b0);
      code(4, 16'h0000);
      chk("active", {31'h0, output_active}, 32'h1);
      wr(8'h00, 32'h129, 1'b0);
      wr(8'h0c, 32'hfffbd501, 1'b1);
      wr(8'h0c, 32'hfffbd502, 1'b0);
      readings.kelvin[0] <= 32'sd0;
      code(110, 16'h8001);
      wr(8'h04, 32'h065, 1'b1);
      wr(8'h04, 32'h032, 1'b0);
      readings.kelvin[0] <= 32'sd400000;
      readings.kelvin[1] <= 32'sd200000;
      wr(8'h00, 32'h047, 1'b0);
      code(4, 16'h0000);
      wr(8'h00, 32'h057, 1'b0);
      code(4, 16'h3fff);
      readings.kelvin[1] <= 32'sd300000;
      code(4, 16'h0000);
      readings.kelvin[1] <= 32'sd299500;
      code(4, 16'h0000);
      readings.kelvin[1] <= 32'sd299000;
      code(4, 16'h3fff);
      rd(8'h00, 32'h057);
      wr(8'h00, 32'h053, 1'b0);
      readings.kelvin[1] <= 32'sd300000;
      code(4, 16'h0000);
      rd(8'h00, 32'h043);
      readings.kelvin[1] <= 32'sd200000;
      code(4, 16'h0000);
      wr(8'h00, 32'h053, 1'b0);
      code(4, 16'h3fff);
      wr(8'h00, 32'h012, 1'b0);
      wr(8'h18, 32'h8000, 1'b0);
      code(4, 16'h0000);
      wr(8'h00, 32'h01a, 1'b0);
      code(4, 16'h8001);
      power_up_enable <= 1'b1;
      arst_n <= 1'b0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge clk);
      rd(8'h00, 32'h014);
      results;
   end
endmodule : aaom_core_tb
